// ---- hw/scia_pkg.sv ----
// Constants, types and helpers shared by the slow-control access logic
package scia_pkg;

  // Port register indices, carried in the low bits of the bus address
  localparam logic [2:0] REG_ADDR_LO = 3'h0;
  localparam logic [2:0] REG_ADDR_HI = 3'h1;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_DATA_INC = 3'h3;
  localparam logic [2:0] REG_DIR_A = 3'h4;
  localparam logic [2:0] REG_DIR_B = 3'h5;
  localparam logic [2:0] REG_DIR_PLL = 3'h6;
  localparam logic [2:0] REG_STATUS = 3'h7;

  // Indirect address layout
  localparam int ADDR_W = 16;
  localparam int SUB_LSB = 5;
  localparam int IDX_W = 5;
  localparam int SUB_W = 11;
  localparam int REGS_PER_SUB = 32;

  // Implemented store: a few sub-blocks, the rest read as the unmapped value
  localparam int CFG_BLOCKS = 4;
  localparam int BLK_SEL_W = 2;
  localparam int CFG_AW = 7;
  localparam int CFG_DEPTH = CFG_BLOCKS * REGS_PER_SUB;
  localparam logic [7:0] CFG_DEFAULT = 8'h00;
  localparam logic [7:0] CFG_UNMAPPED = 8'h00;
  localparam logic [7:0] DIR_DEFAULT = 8'h00;
  localparam logic [15:0] ADDR_DEFAULT = 16'h0000;

  // Status register bit positions
  localparam int STAT_PLL = 0;
  localparam int STAT_SEU = 1;
  localparam int STAT_RSVD = 2;

  // Bus framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [2:0] PIN_IDLE = 3'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WRITE = 3'b011,
    ST_WACK = 3'b100,
    ST_READ = 3'b101,
    ST_RACK = 3'b110
  } scia_state_t;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [7:0] data;
  } scia_cfg_req_t;

  function automatic logic [15:0] addr_incr(input logic [15:0] a);
    addr_incr = a + 16'h0001;
  endfunction

  function automatic logic cfg_hit(input logic [15:0] a);
    cfg_hit = (a[ADDR_W-1:SUB_LSB] < 11'(CFG_BLOCKS));
  endfunction

  function automatic logic [CFG_AW-1:0] cfg_index(input logic [15:0] a);
    cfg_index = {a[SUB_LSB+BLK_SEL_W-1:SUB_LSB], a[IDX_W-1:0]};
  endfunction

endpackage

// ---- hw/scia_cfg_store.sv ----
// Configuration parameter store with per-byte parity upset check
`timescale 1ns/10ps
module scia_cfg_store (
  input wire logic mclk,
  input wire logic prst_n,
  input scia_pkg::scia_cfg_req_t req,
  output logic [7:0] rd_data,
  output logic seu_error
);

  logic [7:0] mem_reg [scia_pkg::CFG_DEPTH];
  logic par_reg [scia_pkg::CFG_DEPTH];
  logic seu_next;
  logic hit;
  logic [scia_pkg::CFG_AW-1:0] idx;

  // Sub-block and index split of the indirect address
  assign hit = scia_pkg::cfg_hit(req.addr);
  assign idx = scia_pkg::cfg_index(req.addr);

  // Only the parameter reset touches this store; hard reset leaves it alone
  always_ff @(posedge mclk or negedge prst_n)
  begin
    if (!prst_n)
    begin
      for (int i = 0; i < scia_pkg::CFG_DEPTH; i++)
      begin
        mem_reg[i] <= scia_pkg::CFG_DEFAULT;
        par_reg[i] <= ^scia_pkg::CFG_DEFAULT;
      end
    end
    else if (req.wr && hit)
    begin
      mem_reg[idx] <= req.data;
      par_reg[idx] <= ^req.data;
    end
  end

  assign rd_data = hit ? mem_reg[idx] : scia_pkg::CFG_UNMAPPED;

  // Parity per byte; a flipped bit anywhere raises the error level
  always_comb
  begin
    seu_next = 1'b0;
    for (int i = 0; i < scia_pkg::CFG_DEPTH; i++)
    begin
      seu_next = seu_next | ((^mem_reg[i]) ^ par_reg[i]);
    end
  end

  always_ff @(posedge mclk or negedge prst_n)
  begin
    if (!prst_n)
      seu_error <= 1'b0;
    else
      seu_error <= seu_next;
  end

  AST_CFG_STORED: assert property (@(posedge mclk) disable iff (!prst_n)
    (req.wr && hit) |=> (mem_reg[$past(idx)] == $past(req.data)))
    else $error("config byte not stored");

endmodule // scia_cfg_store

// ---- hw/scia_top.sv ----
// Bus target with port registers and indirect access to configuration parameters
// What this block does
// - Eight port registers; zero to three reach the configuration parameters only.
// - Registers four, five, six are direct access in one transaction.
// - Register seven is read-only status; writes change nothing.
// - Registers zero and one hold the address of one 8-bit parameter.
// - Indirect address is 16 bits, low byte and high byte registers.
// - Upper 11 bits pick the sub-block, lower 5 the register.
// - At most 32 parameters per sub-block.
// - Writing register two stores its byte at the indirect address.
// - Register three reaches successive addresses without reloading the address.
// - PLL lock is readable in a direct access register.
// - Error output flags an upset in the stored parameters.
// - Direction bit 0 means write, 1 means read.
// - Parameter reset restores parameter defaults and nothing else.
// - Hard reset clears bus logic but keeps the parameters.
`timescale 1ns/10ps
module scia_top #(
  parameter logic [3:0] BUS_ADDR_BASE = 4'h5 // Arbitrary value
) (
  input wire logic mclk,
  input wire logic hard_reset_n,
  input wire logic param_reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic pll_locked,
  output logic [7:0] direct_ctrl_a,
  output logic [7:0] direct_ctrl_b,
  output logic seu_error
);

  logic [1:0] hrst_q;
  logic [1:0] prst_q;
  logic rst_n;
  logic prst_n;
  logic [2:0] pin_q1;
  logic [2:0] pin_q2;
  logic [2:0] pin_q3;
  logic [2:0] pin_reg;
  logic [2:0] pin_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  scia_pkg::scia_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic rw_reg;
  logic nack_reg;
  logic [2:0] idx_reg;
  logic drive_reg;
  logic [15:0] addr_reg;
  logic [7:0] dir_a_reg;
  logic [7:0] dir_b_reg;
  logic [7:0] status;
  logic [7:0] rd_byte;
  logic [7:0] cfg_rd_data;
  logic wr_pulse;
  logic rd_load;
  scia_pkg::scia_cfg_req_t cfg_req;

  // Reset release through two flops per reset
  always_ff @(posedge mclk or negedge hard_reset_n)
  begin
    if (!hard_reset_n)
      hrst_q <= 2'h0;
    else
      hrst_q <= {hrst_q[0], 1'b1};
  end

  always_ff @(posedge mclk or negedge param_reset_n)
  begin
    if (!param_reset_n)
      prst_q <= 2'h0;
    else
      prst_q <= {prst_q[0], 1'b1};
  end

  assign rst_n = hrst_q[1];
  assign prst_n = prst_q[1];

  // Pin inputs: three flops, a change is taken once stages two and three agree
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_q1 <= scia_pkg::PIN_IDLE;
      pin_q2 <= scia_pkg::PIN_IDLE;
      pin_q3 <= scia_pkg::PIN_IDLE;
      pin_reg <= scia_pkg::PIN_IDLE;
      pin_prev_reg <= scia_pkg::PIN_IDLE;
    end
    else
    begin
      pin_q1 <= {pll_locked, sda_in, scl_in};
      pin_q2 <= pin_q1;
      pin_q3 <= pin_q2;
      pin_reg <= (~(pin_q2 ^ pin_q3) & pin_q3) | ((pin_q2 ^ pin_q3) & pin_reg);
      pin_prev_reg <= pin_reg;
    end
  end

  assign scl_rise = pin_reg[0] && !pin_prev_reg[0];
  assign scl_fall = !pin_reg[0] && pin_prev_reg[0];
  assign start_cond = pin_reg[0] && pin_prev_reg[0] && pin_prev_reg[1] && !pin_reg[1];
  assign stop_cond = pin_reg[0] && pin_prev_reg[0] && !pin_prev_reg[1] && pin_reg[1];

  // Byte events seen by the register logic
  assign wr_pulse = (state_reg == scia_pkg::ST_WRITE) && scl_fall && (bit_cnt_reg == scia_pkg::BITS_PER_BYTE);
  assign rd_load = scl_fall && (((state_reg == scia_pkg::ST_AACK) && rw_reg)
    || ((state_reg == scia_pkg::ST_RACK) && !nack_reg));

  // Bit-level sequencer; no clock stretching, so reads are fetched at the ack fall
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= scia_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      idx_reg <= 3'h0;
      drive_reg <= 1'b0;
    end
    else if (start_cond)
    begin
      state_reg <= scia_pkg::ST_ADDR;
      bit_cnt_reg <= 4'h0;
      drive_reg <= 1'b0;
    end
    else if (stop_cond)
    begin
      state_reg <= scia_pkg::ST_IDLE;
      drive_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        scia_pkg::ST_ADDR, scia_pkg::ST_WRITE:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], pin_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && bit_cnt_reg == scia_pkg::BITS_PER_BYTE)
          begin
            if (state_reg == scia_pkg::ST_WRITE)
            begin
              state_reg <= scia_pkg::ST_WACK;
              drive_reg <= 1'b1;
            end
            else if (shift_reg[7:4] == BUS_ADDR_BASE)
            begin
              state_reg <= scia_pkg::ST_AACK;
              drive_reg <= 1'b1;
              rw_reg <= shift_reg[0];
              idx_reg <= shift_reg[3:1];
            end
            else
              state_reg <= scia_pkg::ST_IDLE;
          end
        end
        scia_pkg::ST_AACK, scia_pkg::ST_RACK:
        begin
          if (scl_rise && state_reg == scia_pkg::ST_RACK)
            nack_reg <= pin_reg[1];
          else if (rd_load)
          begin
            state_reg <= scia_pkg::ST_READ;
            tx_reg <= rd_byte;
            drive_reg <= !rd_byte[7];
            bit_cnt_reg <= scia_pkg::BIT_FIRST;
          end
          else if (scl_fall && state_reg == scia_pkg::ST_RACK)
          begin
            state_reg <= scia_pkg::ST_IDLE;
            drive_reg <= 1'b0;
          end
          else if (scl_fall)
          begin
            state_reg <= scia_pkg::ST_WRITE;
            drive_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
          end
        end
        scia_pkg::ST_WACK:
        begin
          if (scl_fall)
          begin
            state_reg <= scia_pkg::ST_WRITE;
            drive_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
          end
        end
        scia_pkg::ST_READ:
        begin
          if (scl_fall && bit_cnt_reg == scia_pkg::BITS_PER_BYTE)
          begin
            state_reg <= scia_pkg::ST_RACK;
            drive_reg <= 1'b0;
          end
          else if (scl_fall)
          begin
            drive_reg <= !tx_reg[6];
            tx_reg <= {tx_reg[6:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        default:
          state_reg <= scia_pkg::ST_IDLE;
      endcase
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = !drive_reg;

  // Address and direct registers; hard reset clears them, parameters survive
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_reg <= scia_pkg::ADDR_DEFAULT;
      dir_a_reg <= scia_pkg::DIR_DEFAULT;
      dir_b_reg <= scia_pkg::DIR_DEFAULT;
    end
    else if (wr_pulse)
    begin
      case (idx_reg)
        scia_pkg::REG_ADDR_LO: addr_reg[7:0] <= shift_reg;
        scia_pkg::REG_ADDR_HI: addr_reg[15:8] <= shift_reg;
        scia_pkg::REG_DATA_INC: addr_reg <= scia_pkg::addr_incr(addr_reg);
        scia_pkg::REG_DIR_A: dir_a_reg <= shift_reg;
        scia_pkg::REG_DIR_B: dir_b_reg <= shift_reg;
        default: addr_reg <= addr_reg; // Status and lock register ignore writes
      endcase
    end
    else if (rd_load && idx_reg == scia_pkg::REG_DATA_INC)
      addr_reg <= scia_pkg::addr_incr(addr_reg);
  end

  // One driver for the whole request word
  assign cfg_req = '{
    wr: wr_pulse && (idx_reg == scia_pkg::REG_DATA || idx_reg == scia_pkg::REG_DATA_INC),
    addr: addr_reg,
    data: shift_reg
  };

  assign status = {5'h00, |addr_reg[15:14], seu_error, pin_reg[2]};

  always_comb
  begin
    case (idx_reg)
      scia_pkg::REG_ADDR_LO: rd_byte = addr_reg[7:0];
      scia_pkg::REG_ADDR_HI: rd_byte = addr_reg[15:8];
      scia_pkg::REG_DATA, scia_pkg::REG_DATA_INC: rd_byte = cfg_rd_data;
      scia_pkg::REG_DIR_A: rd_byte = dir_a_reg;
      scia_pkg::REG_DIR_B: rd_byte = dir_b_reg;
      scia_pkg::REG_DIR_PLL: rd_byte = {7'h00, pin_reg[2]};
      default: rd_byte = status;
    endcase
  end

  scia_cfg_store u_store (
    .mclk(mclk),
    .prst_n(prst_n),
    .req(cfg_req),
    .rd_data(cfg_rd_data),
    .seu_error(seu_error)
  );

  assign direct_ctrl_a = dir_a_reg;
  assign direct_ctrl_b = dir_b_reg;

  AST_ADDR_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_pulse && idx_reg == scia_pkg::REG_ADDR_LO) |=> (addr_reg[7:0] == $past(shift_reg)) && $stable(addr_reg[15:8]))
    else $error("low address byte not loaded");
  AST_ADDR_HIGH: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_pulse && idx_reg == scia_pkg::REG_ADDR_HI) |=> (addr_reg[15:8] == $past(shift_reg)) && $stable(addr_reg[7:0]))
    else $error("high address byte not loaded");
  AST_DATA_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_pulse && idx_reg == scia_pkg::REG_DATA) |-> cfg_req.wr && (cfg_req.addr == addr_reg) ##1 $stable(addr_reg))
    else $error("data write misrouted");
  AST_AUTOINC: assert property (@(posedge mclk) disable iff (!rst_n)
    ((wr_pulse || rd_load) && idx_reg == scia_pkg::REG_DATA_INC) |=> (addr_reg == $past(addr_reg) + 16'h0001))
    else $error("auto-increment missed");
  AST_STATUS_RO: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_pulse && idx_reg == scia_pkg::REG_STATUS) |=> $stable(addr_reg) && $stable(dir_a_reg) && $stable(dir_b_reg))
    else $error("status write had an effect");
  AST_DIRECT: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_pulse && idx_reg == scia_pkg::REG_DIR_A) |=> (direct_ctrl_a == $past(shift_reg)))
    else $error("direct register not written");
  AST_PLL_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_load && idx_reg == scia_pkg::REG_DIR_PLL) |=> (tx_reg[0] == $past(pin_reg[2])) && (tx_reg[7:1] == 7'h00))
    else $error("lock bit not returned");
  AST_DATA_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_load && idx_reg == scia_pkg::REG_DATA) |=> (tx_reg == $past(cfg_rd_data)) && (state_reg == scia_pkg::ST_READ))
    else $error("parameter read wrong");
  AST_DIRECTION: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_reg == scia_pkg::ST_AACK && scl_fall && !start_cond && !stop_cond)
      |=> (state_reg == (rw_reg ? scia_pkg::ST_READ : scia_pkg::ST_WRITE)))
    else $error("direction bit not honoured");

endmodule // scia_top

// ---- dv/scia_master_model.sv ----
// Bus master model driving clock and data lines of the target
`timescale 1ns/10ps
module scia_master_model (
  input wire logic mclk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_m
);
  // Idle bus: both lines released, clock stands still
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // Quarter of the 320 ns bus period, always just after an mclk edge
  task automatic q();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic start();
    sda_m = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_m = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask

  task automatic stop();
    sda_m = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_m = 1'b1;
    q();
  endtask

  // Low for six cycles, high for two: the target answers five cycles after a fall,
  // so its data settles before the next rise instead of mimicking a start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    q();
    q();
    scl = 1'b1;
    q();
    r = sda_wire;
    scl = 1'b0;
    q();
  endtask

  // Byte out MSB first, then the ninth bit; FF lets the target drive
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(last, ack);
  endtask
endmodule // scia_master_model

// ---- dv/test_scia_top.sv ----
// Self-checking bench for the slow-control access logic
`timescale 1ns/10ps
module test_scia_top;
  localparam logic [3:0] BUS_BASE = 4'h5;
  logic mclk, hard_reset_n, param_reset_n, pll_locked, scl, sda_m, sda_out, sda_oe_n, seu_error, sda_wire;
  logic [7:0] direct_ctrl_a, direct_ctrl_b;
  int errors = 0;
  int total_checks = 0;

  // Open drain: target pulls low, otherwise the pull-up or master decides
  assign sda_wire = sda_m & (sda_oe_n | sda_out);

  scia_top #(.BUS_ADDR_BASE(BUS_BASE)) scia_top_i (.mclk(mclk), .hard_reset_n(hard_reset_n),
    .param_reset_n(param_reset_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .pll_locked(pll_locked), .direct_ctrl_a(direct_ctrl_a), .direct_ctrl_b(direct_ctrl_b),
    .seu_error(seu_error));
  scia_master_model scia_master_model_i (.mclk(mclk), .sda_wire(sda_wire), .scl(scl), .sda_m(sda_m));

  always #20 mclk = ~mclk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic open(input logic [2:0] idx, input logic rd);
    logic [7:0] r;
    logic a;
    scia_master_model_i.start();
    scia_master_model_i.xfer({BUS_BASE, idx, rd}, 1'b1, r, a);
    chk1(a, 1'b0);
  endtask

  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic a;
    open(idx, 1'b0);
    scia_master_model_i.xfer(d, 1'b1, r, a);
    chk1(a, 1'b0);
    scia_master_model_i.stop();
  endtask

  task automatic rd(input logic [2:0] idx, output logic [7:0] d);
    logic a;
    open(idx, 1'b1);
    scia_master_model_i.xfer(8'hFF, 1'b1, d, a);
    scia_master_model_i.stop();
  endtask

  // Top two address bits always zero; test bytes never disable the reference channels
  task automatic setaddr(input logic [15:0] a);
    wr(3'h0, a[7:0]);
    wr(3'h1, {2'b00, a[13:8]});
  endtask

  task automatic rdchk(input logic [2:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    rd(idx, v);
    chk8(v, exp);
  endtask

  task automatic pulse(input logic hard);
    @(posedge mclk);
    #1;
    if (hard)
      hard_reset_n = 1'b0;
    else
      param_reset_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    hard_reset_n = 1'b1;
    param_reset_n = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
  endtask

  task automatic t_indirect();
    setaddr(16'h005F);
    wr(3'h2, 8'hA5);
    setaddr(16'h003F);
    wr(3'h2, 8'h3C);
    setaddr(16'h005F);
    rdchk(3'h2, 8'hA5);
    rdchk(3'h0, 8'h5F);
    setaddr(16'h003F);
    rdchk(3'h2, 8'h3C);
    setaddr(16'h0080);
    wr(3'h2, 8'h77);
    rdchk(3'h2, 8'h00);
    $display("test indirect done");
  endtask

  task automatic t_autoinc();
    logic [7:0] r;
    logic a;
    setaddr(16'h001E);
    open(3'h3, 1'b0);
    for (int i = 1; i <= 3; i++)
      scia_master_model_i.xfer(8'(i * 17), 1'b1, r, a);
    scia_master_model_i.stop();
    rdchk(3'h0, 8'h21);
    setaddr(16'h001E);
    open(3'h3, 1'b1);
    for (int i = 1; i <= 3; i++)
    begin
      scia_master_model_i.xfer(8'hFF, i == 3, r, a);
      chk8(r, 8'(i * 17));
    end
    scia_master_model_i.stop();
    rdchk(3'h0, 8'h21);
    rdchk(3'h1, 8'h00);
    $display("test autoinc done");
  endtask

  task automatic t_direct();
    wr(3'h4, 8'h5A);
    wr(3'h5, 8'hC3);
    chk8(direct_ctrl_a, 8'h5A);
    chk8(direct_ctrl_b, 8'hC3);
    rdchk(3'h5, 8'hC3);
    for (int p = 0; p < 2; p++)
    begin
      pll_locked = p[0];
      wr(3'h6, 8'hFE);
      wr(3'h7, 8'hFF);
      rdchk(3'h6, {7'h00, p[0]});
      rdchk(3'h7, {7'h00, p[0]});
    end
    $display("test direct done");
  endtask

  task automatic t_refuse();
    logic [7:0] r;
    logic a;
    scia_master_model_i.start();
    scia_master_model_i.xfer({~BUS_BASE, 3'h4, 1'b0}, 1'b1, r, a);
    chk1(a, 1'b1);
    scia_master_model_i.stop();
    rdchk(3'h4, 8'h5A);
    $display("test refuse done");
  endtask

  task automatic t_resets();
    setaddr(16'h0005);
    wr(3'h2, 8'h9C);
    pulse(1'b1);
    chk8(direct_ctrl_a, 8'h00);
    rdchk(3'h0, 8'h00);
    setaddr(16'h0005);
    rdchk(3'h2, 8'h9C);
    wr(3'h4, 8'hA5);
    pulse(1'b0);
    chk8(direct_ctrl_a, 8'hA5);
    rdchk(3'h0, 8'h05);
    rdchk(3'h2, 8'h00);
    chk1(seu_error, 1'b0);
    $display("test resets done");
  endtask

  // Hang guard: a run past this bound counts as a mismatch
  initial
  begin
    repeat (100000) @(posedge mclk);
    errors++;
    print_verdict();
  end

  initial
  begin
    mclk = 1'b0;
    hard_reset_n = 1'b0;
    param_reset_n = 1'b0;
    pll_locked = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    hard_reset_n = 1'b1;
    param_reset_n = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chk8(direct_ctrl_b, 8'h00);
    rdchk(3'h1, 8'h00);
    t_indirect();
    t_autoinc();
    t_direct();
    t_refuse();
    t_resets();
    print_verdict();
  end
endmodule // test_scia_top
